// *** hdl/tmc_top.sv ***
// temperature monitor calculation block with its paged register file on Wishbone
// assumes synchronous inputs, a classic Wishbone master and 8-bit data in lane 0
`timescale 1ns/1ps
module tmc_top
  import tmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tmc_pkg::tmc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tm_osc_i,
  input wire logic sof_i,
  input wire logic [15:0] otp_slope_i,
  input wire logic [31:0] otp_offset_i,
  output logic [7:0] temp_int_o,
  output logic [7:0] temp_dec_o
);
  import tmc_pkg::*;

  tmc_st_t s_q;
  tmc_st_t s_d;

  // ==========================================================
  // register read decode
  function automatic logic [7:0] rd_byte(input tmc_st_t s, input logic [7:0] idx,
                                         input logic mon);
    logic [7:0] r;
    r = 8'h00;
    if (idx == A_PAGE)
      r = s.page;
    else if (mon)
    begin
      case (idx)
        A_SLOPE_H: r = s.slope[15:8];
        A_SLOPE_L: r = s.slope[7:0];
        A_OFS_3: r = s.ofs[31:24];
        A_OFS_2: r = s.ofs[23:16];
        A_OFS_1: r = s.ofs[15:8];
        A_OFS_0: r = s.ofs[7:0];
        A_DIV: r = s.div;
        A_CNT_SEL: r = {5'h00, s.cnt_sel};
        A_OTP_EN: r = {7'h00, s.otp_en};
        A_SOF_EN: r = {7'h00, s.sof_en};
        A_SHIFT: r = {3'h0, s.shift};
        A_PD: r = {7'h00, s.pd};
        A_DIV_ORD: r = {7'h00, s.div_ord};
        A_MUL_DIV: r = {7'h00, s.mul_div};
        A_FLOOR: r = s.floor;
        A_CEIL: r = s.ceil;
        A_FORCE: r = {7'h00, s.force_lat};
        A_LAT_INT: r = s.lat_int;
        A_LAT_DEC: r = s.lat_dec;
        A_LIVE_INT: r = s.live_int;
        A_LIVE_DEC: r = s.live_dec;
        A_NUM: r = s.num;
        A_REAL_H: r = s.meas_real[15:8];
        A_REAL_L: r = s.meas_real[7:0];
        A_ABS_3: r = s.abs_res[31:24];
        A_ABS_2: r = s.abs_res[23:16];
        A_ABS_1: r = s.abs_res[15:8];
        A_ABS_0: r = s.abs_res[7:0];
        A_SUM_3: r = s.sum[31:24];
        A_SUM_2: r = s.sum[23:16];
        A_SUM_1: r = s.sum[15:8];
        A_SUM_0: r = s.sum[7:0];
        A_VAL_H: r = s.value[15:8];
        A_VAL_L: r = s.value[7:0];
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    logic hit;
    logic in_map;
    logic mon;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] div_last;
    logic tick;
    logic [15:0] acc_n;
    logic [16:0] win;
    logic [16:0] rem;
    logic qbit;
    logic [31:0] sum_n;
    logic [31:0] shifted;
    logic [15:0] val;
    logic done;
    logic lat_go;
    hit = 1'b0;
    in_map = 1'b0;
    mon = 1'b0;
    wr = 1'b0;
    idx = 8'h00;
    wd = 8'h00;
    div_last = 8'h00;
    tick = 1'b0;
    acc_n = 16'h0000;
    win = 17'h0_0000;
    rem = 17'h0_0000;
    qbit = 1'b0;
    sum_n = 32'h0000_0000;
    shifted = 32'h0000_0000;
    val = 16'h0000;
    done = 1'b0;
    lat_go = 1'b0;
    s_d = s_q;

    // bus slave: one wait state, ack drops the cycle after it is given
    hit = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
    in_map = (wb_req_i.adr[11:10] == 2'b00);
    idx = wb_req_i.adr[9:2];
    mon = (s_q.page[3:0] == PAGE_MON);
    wr = hit & wb_req_i.we & wb_req_i.sel[0] & in_map;
    wd = wb_req_i.dat[7:0];
    s_d.ack = hit;
    if (hit)
      s_d.rdat = in_map ? rd_byte(s_q, idx, mon) : 8'h00;

    // otp coefficients override software values while enabled
    if (s_q.otp_en)
    begin
      s_d.slope = otp_slope_i;
      s_d.ofs = otp_offset_i;
    end

    // sampling tick; a zero setting behaves as divide by one
    div_last = (s_q.div == 8'h00) ? 8'h00 : s_q.div - 8'h01;
    tick = (s_q.tick_cnt >= div_last);
    s_d.tick_cnt = tick ? 8'h00 : s_q.tick_cnt + 8'h01;

    win = 17'h0_0001 << (WIN_EXP_BASE + int'(s_q.cnt_sel));
    acc_n = s_q.acc;
    if (tm_osc_i & ~s_q.osc_prev & (s_q.acc != 16'hffff))
      acc_n = s_q.acc + 16'h0001;

    case (s_q.fsm)
      S_IDLE:
      begin
        if (!s_q.pd)
        begin
          s_d.fsm = S_COUNT;
          s_d.samp_cnt = 16'h0000;
          s_d.acc = 16'h0000;
          s_d.osc_prev = tm_osc_i;
        end
      end
      S_COUNT:
      begin
        if (s_q.pd)
          s_d.fsm = S_IDLE;
        else if (tick)
        begin
          s_d.osc_prev = tm_osc_i;
          s_d.acc = acc_n;
          s_d.samp_cnt = s_q.samp_cnt + 16'h0001;
          if ({1'b0, s_q.samp_cnt} == win - 17'h0_0001)
          begin
            s_d.meas_real = acc_n;
            if (s_q.mul_div)
            begin
              // numerator shifts out while quotient bits shift in
              s_d.dv_q = s_q.div_ord ? s_q.slope : acc_n;
              s_d.dv_d = s_q.div_ord ? acc_n : s_q.slope;
              s_d.dv_r = 17'h0_0000;
              s_d.dv_n = 5'h00;
              s_d.fsm = S_DIV;
            end
            else
            begin
              s_d.abs_res = {16'h0000, acc_n} * {16'h0000, s_q.slope};
              s_d.fsm = S_DONE;
            end
          end
        end
      end
      S_DIV:
      begin
        // restoring division, one quotient bit per clock; divide by zero gives all ones
        rem = {s_q.dv_r[15:0], s_q.dv_q[15]};
        qbit = (rem >= {1'b0, s_q.dv_d});
        if (qbit)
          rem = rem - {1'b0, s_q.dv_d};
        s_d.dv_r = rem;
        s_d.dv_q = {s_q.dv_q[14:0], qbit};
        s_d.dv_n = s_q.dv_n + 5'h01;
        if (s_q.dv_n == DIV_LAST)
        begin
          s_d.abs_res = {16'h0000, s_q.dv_q[14:0], qbit};
          s_d.fsm = S_DONE;
        end
      end
      S_DONE:
      begin
        sum_n = s_q.abs_res + s_q.ofs;
        shifted = sum_n >> s_q.shift;
        val = shifted[15:0];
        if (val[15:8] < s_q.floor)
          val = {s_q.floor, 8'h00};
        // ceiling checked last so it wins when limits cross
        if (val[15:8] > s_q.ceil)
          val = {s_q.ceil, 8'h00};
        s_d.sum = sum_n;
        s_d.value = val;
        s_d.live_int = val[15:8];
        s_d.live_dec = val[7:0];
        s_d.num = s_q.num + 8'h01;
        done = 1'b1;
        s_d.fsm = S_IDLE;
      end
      default: s_d.fsm = S_IDLE;
    endcase

    // latch follows completion, or frame start in its place when enabled, or force
    lat_go = (s_q.sof_en ? sof_i : done) | s_q.force_lat;
    if (lat_go)
    begin
      s_d.lat_int = s_d.live_int;
      s_d.lat_dec = s_d.live_dec;
    end
    if (s_q.force_lat)
      s_d.force_lat = 1'b0;

    // software writes last, so a write of force in the clearing cycle wins
    if (wr)
    begin
      if (idx == A_PAGE)
        s_d.page = wd;
      else if (mon)
      begin
        case (idx)
          A_SLOPE_H: s_d.slope[15:8] = wd;
          A_SLOPE_L: s_d.slope[7:0] = wd;
          A_OFS_3: s_d.ofs[31:24] = wd;
          A_OFS_2: s_d.ofs[23:16] = wd;
          A_OFS_1: s_d.ofs[15:8] = wd;
          A_OFS_0: s_d.ofs[7:0] = wd;
          A_DIV: s_d.div = wd;
          A_CNT_SEL: s_d.cnt_sel = wd[2:0];
          A_OTP_EN: s_d.otp_en = wd[0];
          A_SOF_EN: s_d.sof_en = wd[0];
          A_SHIFT: s_d.shift = wd[4:0];
          A_PD: s_d.pd = wd[0];
          A_DIV_ORD: s_d.div_ord = wd[0];
          A_MUL_DIV: s_d.mul_div = wd[0];
          A_FLOOR: s_d.floor = wd;
          A_CEIL: s_d.ceil = wd;
          A_FORCE: s_d.force_lat = wd[0];
          default: s_d.page = s_d.page;
        endcase
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.page <= RST_PAGE;
      s_q.slope <= RST_SLOPE;
      s_q.ofs <= RST_OFS;
      s_q.div <= RST_DIV;
      s_q.cnt_sel <= RST_CNT_SEL;
      s_q.shift <= RST_SHIFT;
      s_q.floor <= RST_FLOOR;
      s_q.ceil <= RST_CEIL;
      s_q.fsm <= S_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign wb_dat_o = {24'h00_0000, s_q.rdat};
  assign wb_ack_o = s_q.ack;
  assign temp_int_o = s_q.lat_int;
  assign temp_dec_o = s_q.lat_dec;
endmodule

// *** hdl/tmc_pkg.sv ***
// register map, reset values, state and carrier types of the temperature monitor
// assumes a 40 MHz core clock and an 8-bit register file behind Wishbone
package tmc_pkg;
  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] A_SLOPE_H = 8'h00;
  localparam logic [7:0] A_SLOPE_L = 8'h01;
  localparam logic [7:0] A_OFS_3 = 8'h02;
  localparam logic [7:0] A_OFS_2 = 8'h03;
  localparam logic [7:0] A_OFS_1 = 8'h04;
  localparam logic [7:0] A_OFS_0 = 8'h05;
  localparam logic [7:0] A_DIV = 8'h06;
  localparam logic [7:0] A_CNT_SEL = 8'h07;
  localparam logic [7:0] A_OTP_EN = 8'h0a;
  localparam logic [7:0] A_SOF_EN = 8'h0b;
  localparam logic [7:0] A_SHIFT = 8'h0c;
  localparam logic [7:0] A_PD = 8'h0d;
  localparam logic [7:0] A_DIV_ORD = 8'h0e;
  localparam logic [7:0] A_MUL_DIV = 8'h0f;
  localparam logic [7:0] A_FLOOR = 8'h10;
  localparam logic [7:0] A_CEIL = 8'h11;
  localparam logic [7:0] A_FORCE = 8'h12;
  localparam logic [7:0] A_LAT_INT = 8'h13;
  localparam logic [7:0] A_LAT_DEC = 8'h14;
  localparam logic [7:0] A_LIVE_INT = 8'h15;
  localparam logic [7:0] A_LIVE_DEC = 8'h16;
  localparam logic [7:0] A_NUM = 8'h17;
  localparam logic [7:0] A_REAL_H = 8'h18;
  localparam logic [7:0] A_REAL_L = 8'h19;
  localparam logic [7:0] A_ABS_3 = 8'h1a;
  localparam logic [7:0] A_ABS_2 = 8'h1b;
  localparam logic [7:0] A_ABS_1 = 8'h1c;
  localparam logic [7:0] A_ABS_0 = 8'h1d;
  localparam logic [7:0] A_SUM_3 = 8'h1e;
  localparam logic [7:0] A_SUM_2 = 8'h1f;
  localparam logic [7:0] A_SUM_1 = 8'h20;
  localparam logic [7:0] A_SUM_0 = 8'h21;
  localparam logic [7:0] A_VAL_H = 8'h22;
  localparam logic [7:0] A_VAL_L = 8'h23;
  localparam logic [7:0] A_PAGE = 8'hfd;
  // ==========================================================
  // reset values and codes
  localparam logic [15:0] RST_SLOPE = 16'h0519;
  localparam logic [31:0] RST_OFS = 32'hfdd1_ffff;
  localparam logic [7:0] RST_DIV = 8'h08;
  localparam logic [2:0] RST_CNT_SEL = 3'h7;
  localparam logic [4:0] RST_SHIFT = 5'h05;
  localparam logic [7:0] RST_FLOOR = 8'h00;
  localparam logic [7:0] RST_CEIL = 8'hff;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [3:0] PAGE_MON = 4'h6;
  localparam int WIN_EXP_BASE = 9;
  localparam logic [4:0] DIV_LAST = 5'h0f;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_COUNT = 2'b01,
    S_DIV = 2'b11,
    S_DONE = 2'b10
  } tmc_fsm_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tmc_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] page;
    logic [15:0] slope;
    logic [31:0] ofs;
    logic [7:0] div;
    logic [2:0] cnt_sel;
    logic otp_en;
    logic sof_en;
    logic [4:0] shift;
    logic pd;
    logic div_ord;
    logic mul_div;
    logic [7:0] floor;
    logic [7:0] ceil;
    logic force_lat;
    logic [7:0] lat_int;
    logic [7:0] lat_dec;
    logic [7:0] live_int;
    logic [7:0] live_dec;
    logic [7:0] num;
    logic [15:0] meas_real;
    logic [31:0] abs_res;
    logic [31:0] sum;
    logic [15:0] value;
    tmc_fsm_t fsm;
    logic [7:0] tick_cnt;
    logic [15:0] samp_cnt;
    logic osc_prev;
    logic [15:0] acc;
    logic [15:0] dv_q;
    logic [16:0] dv_r;
    logic [15:0] dv_d;
    logic [4:0] dv_n;
  } tmc_st_t;
endpackage

// *** verif/tmc_top_chk.sv ***
// port assertions for tmc_top, bound into every instance
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module tmc_top_chk
  import tmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tmc_pkg::tmc_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tm_osc_i,
  input wire logic sof_i,
  input wire logic [15:0] otp_slope_i,
  input wire logic [31:0] otp_offset_i,
  input wire logic [7:0] temp_int_o,
  input wire logic [7:0] temp_dec_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ====
  // bus handshake
  sequence s_take;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_timing: assert property (s_take |=> s_pulse)
    else $error("request not answered in one cycle");
  a_ack_gap: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_req_i.stb) && $past(wb_req_i.cyc))
    else $error("ack without request");
  a_idle_quiet: assert property ((!wb_req_i.stb) [*2] |-> !wb_ack_o)
    else $error("ack while bus idle");
  // ====
  // read data and results
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_hole_zero: assert property (wb_ack_o && wb_req_i.adr[9:2] == 8'h08 |-> wb_dat_o == '0)
    else $error("reserved index reads nonzero");
  a_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && {temp_int_o, temp_dec_o} == '0)
    else $error("outputs not cleared by reset");
  a_no_early: assert property ($fell(rst_i) |-> (temp_int_o == 8'h00) [*8])
    else $error("result latched before a window ended");
endmodule
bind tmc_top tmc_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tm_osc_i(tm_osc_i), .sof_i(sof_i),
  .otp_slope_i(otp_slope_i), .otp_offset_i(otp_offset_i), .temp_int_o(temp_int_o),
  .temp_dec_o(temp_dec_o));

// *** verif/tmc_top_tb.sv ***
// self-checking bench for tmc_top: wishbone tasks and measurement runs
// assumes the oscillator is a clean square wave made by the bench
`timescale 1ns/1ps
`define check_eq(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tmc_top_tb;
  import tmc_pkg::*;
  logic clk_i = 0, rst_i = 1, osc = 0, sof = 0, ack;
  tmc_wb_req_t req = '0;
  logic [31:0] dat, ot_o = 32'h0000_0100;
  logic [15:0] ot_s = 16'h1234;
  logic [7:0] ti, td, r;
  int fail_count = 0, num_checks = 0, cyc_n = 0;
  logic [7:0] ra [10] = '{A_SLOPE_H, A_SLOPE_L, A_OFS_3, A_OFS_0, A_DIV, A_CNT_SEL,
    A_SHIFT, A_FLOOR, A_CEIL, A_FORCE};
  logic [7:0] rv [10] = '{8'h05, 8'h19, 8'hfd, 8'hff, 8'h08, 8'h07, 8'h05, 8'h00, 8'hff, 8'h00};
  tmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
    .tm_osc_i(osc), .sof_i(sof), .otp_slope_i(ot_s), .otp_offset_i(ot_o),
    .temp_int_o(ti), .temp_dec_o(td));
  initial forever #12.5 clk_i = ~clk_i;
  // ====
  // oscillator: period of four clocks; watchdog
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    osc <= cyc_n[1];
    if (cyc_n > 60000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // request stands until ack is seen high at a rising edge; data is taken at that same edge
  // no cycle count is assumed: only the watchdog ends a wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b1, w, {2'b00, a, 2'b00}, 4'h1, {24'h00_0000, d}};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    r = dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // ====
  // one window with the given arithmetic, latch and clamp settings, then frozen
  task automatic run(input logic md, od, sf, fo, ot, input logic [7:0] fl, ce, dv);
    logic [15:0] c, s, q, v, pv;
    logic [31:0] o, ab, su;
    logic [7:0] n0;
    int k = 0;
    s = ot ? ot_s : RST_SLOPE;
    o = ot ? ot_o : RST_OFS;
    xfer(0, A_LAT_INT, 0);
    pv[15:8] = r;
    xfer(0, A_LAT_DEC, 0);
    pv[7:0] = r;
    xfer(0, A_NUM, 0);
    n0 = r;
    xfer(1, A_MUL_DIV, {7'h00, md});
    xfer(1, A_DIV_ORD, {7'h00, od});
    xfer(1, A_SOF_EN, {7'h00, sf});
    xfer(1, A_OTP_EN, {7'h00, ot});
    xfer(1, A_DIV, dv);
    xfer(1, A_FLOOR, fl);
    xfer(1, A_CEIL, ce);
    xfer(1, A_PD, 8'h00);
    do
      xfer(0, A_NUM, 0);
    while (r === n0 && ++k < 600);
    `check_eq(r, 8'(n0 + 1))
    xfer(1, A_PD, 8'h01);
    if (ot)
    begin
      xfer(0, A_SLOPE_H, 0);
      `check_eq(r, ot_s[15:8])
    end
    xfer(0, A_REAL_H, 0);
    c[15:8] = r;
    xfer(0, A_REAL_L, 0);
    c[7:0] = r;
    // one oscillator edge per four clocks: 512 ticks of dv clocks see about 128 * dv edges
    `check_eq(c > 16'd120 * {8'h00, dv} && c < 16'd136 * {8'h00, dv}, 1'b1)
    q = od ? (c == 0 ? 16'hffff : s / c) : (s == 0 ? 16'hffff : c / s);
    ab = md ? {16'h0000, q} : c * s;
    su = ab + o;
    v = 16'(su >> RST_SHIFT);
    if (v[15:8] < fl)
      v = {fl, 8'h00};
    if (v[15:8] > ce)
      v = {ce, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      xfer(0, 8'(A_ABS_3 + i), 0);
      `check_eq(r, ab[31 - 8 * i -: 8])
      xfer(0, 8'(A_SUM_3 + i), 0);
      `check_eq(r, su[31 - 8 * i -: 8])
    end
    xfer(0, A_VAL_H, 0);
    `check_eq(r, v[15:8])
    xfer(0, A_VAL_L, 0);
    `check_eq(r, v[7:0])
    xfer(0, A_LIVE_INT, 0);
    `check_eq(r, v[15:8])
    xfer(0, A_LIVE_DEC, 0);
    `check_eq(r, v[7:0])
    xfer(0, A_LAT_INT, 0);
    `check_eq(r, sf ? pv[15:8] : v[15:8])
    `check_eq({ti, td}, sf ? pv : v)
    if (fo)
      xfer(1, A_FORCE, 8'h01);
    else if (sf)
    begin
      sof <= 1'b1;
      @(posedge clk_i);
      sof <= 1'b0;
    end
    xfer(0, A_FORCE, 0);
    `check_eq(r, 8'h00)
    xfer(0, A_LAT_DEC, 0);
    `check_eq(r, v[7:0])
    `check_eq({ti, td}, v)
  endtask
  // ====
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(0, A_SLOPE_H, 0);
    `check_eq(r, 8'h00)
    xfer(1, A_PAGE, {4'h0, PAGE_MON});
    xfer(0, A_PAGE, 0);
    `check_eq(r, 8'h06)
    foreach (ra[i])
    begin
      xfer(0, ra[i], 0);
      `check_eq(r, rv[i])
    end
    xfer(1, A_LAT_INT, 8'ha5);
    xfer(0, A_LAT_INT, 0);
    `check_eq(r, 8'h00)
    xfer(1, 8'h08, 8'h5a);
    xfer(0, 8'h08, 0);
    `check_eq(r, 8'h00)
    xfer(1, A_PD, 8'h01);
    xfer(1, A_DIV, 8'h01);
    xfer(1, A_CNT_SEL, 8'h00);
    xfer(0, A_DIV, 0);
    `check_eq(r, 8'h01)
    run(0, 0, 0, 0, 0, 8'h00, 8'hff, 8'h01);
    run(1, 0, 1, 1, 0, 8'h00, 8'h10, 8'h01);
    run(1, 1, 1, 0, 1, 8'h20, 8'hff, 8'h02);
    xfer(1, A_PAGE, 8'h00);
    xfer(0, A_SLOPE_L, 0);
    `check_eq(r, 8'h00)
    conclude();
  end
endmodule
